// [core/sdw_pkg.sv]
// Purpose: shared constants and carrier types for the staged digital watchdogs
// Assumes: single 40 MHz clock, classic wishbone register access
// Notes:   byte offsets are relative to the block base
package sdw_pkg;
	localparam int NUM_WDT   = 3;
	localparam int NUM_STAGE = 4;
	localparam int CNT_W     = 32;
	localparam int RTC_IDX   = 2;
	localparam int FAST_DIV_W = 8;          // fast rc divided by 256

	// stage actions
	localparam logic [2:0] ACT_OFF  = 3'h0;
	localparam logic [2:0] ACT_INT  = 3'h1;
	localparam logic [2:0] ACT_CPU  = 3'h2;
	localparam logic [2:0] ACT_CORE = 3'h3;
	localparam logic [2:0] ACT_SYS  = 3'h4;

	// rtc slow clock source select
	localparam logic [1:0] CLK_XTAL32K  = 2'h0;
	localparam logic [1:0] CLK_SLOW_RC  = 2'h1;
	localparam logic [1:0] CLK_FAST_DIV = 2'h2;
	localparam logic [1:0] CLKSEL_RST   = 2'h0;

	// per-watchdog register offsets, watchdog n at n * 0x40
	localparam logic [5:0] OFS_CONFIG = 6'h00;
	localparam logic [5:0] OFS_STAGE0 = 6'h04;
	localparam logic [5:0] OFS_STAGE3 = 6'h10;
	localparam logic [5:0] OFS_FEED   = 6'h14;
	localparam logic [5:0] OFS_WPROT  = 6'h18;
	localparam logic [5:0] OFS_STATUS = 6'h1C;
	localparam logic [5:0] OFS_COUNT  = 6'h20;
	// global registers
	localparam logic [7:0] OFS_CLKSEL = 8'hC0;
	localparam logic [7:0] OFS_STRAP  = 8'hC4;
	localparam logic [1:0] GLOBAL_IDX = 2'h3;

	// config word field positions
	localparam int CFG_EN_BIT  = 0;
	localparam int CFG_SEN_LSB = 4;
	localparam int CFG_ACT_LSB = 8;

	localparam logic [31:0] WPROT_KEY = 32'h5A5A_A5A5;   // arbitrary unlock key
	localparam logic        LOCK_RST  = 1'b1;

	typedef struct packed {
		logic                             wd_en;
		logic [NUM_STAGE-1:0]             stage_en;
		logic [NUM_STAGE-1:0][2:0]        act;
		logic [NUM_STAGE-1:0][CNT_W-1:0]  tmo;
	} sdw_cfg_t;

	typedef struct packed {
		logic [CNT_W-1:0] count;
		logic [1:0]       stage;
		logic             irq;
	} sdw_stat_t;

	typedef struct packed {
		logic cpu;
		logic core;
		logic sys;
	} sdw_rst_t;
endpackage

// [core/sdw_wdt_core.sv]
// Purpose: one four-stage watchdog counter with per-stage actions
// Assumes: tick is a one-cycle count enable, feed a one-cycle pulse
// Notes:   reset requests are one-cycle pulses
`timescale 1ns/1ps
module sdw_wdt_core #(
	parameter bit ALLOW_SYS = 1'b0
) (
	input  wire logic          clk,
	input  wire logic          srst,
	input  wire logic          tick,
	input  wire logic          feed,
	input  sdw_pkg::sdw_cfg_t  cfg,
	output sdw_pkg::sdw_stat_t stat,
	output sdw_pkg::sdw_rst_t  rst_req
);
	import sdw_pkg::*;

	logic [CNT_W-1:0] cnt_r;
	logic [1:0]       stage_r;
	logic             irq_r;
	sdw_rst_t         rst_r;
	logic [2:0]       act;
	logic             live;
	logic             hit;
	logic             expire;
	logic             is_rst;

	// map an action code to reset requests; main watchdogs cannot ask for system reset
	function automatic sdw_rst_t decode_rst(input logic [2:0] a, input logic allow_sys);
		sdw_rst_t r;
		r      = '0;
		r.cpu  = (a == ACT_CPU);
		r.core = (a == ACT_CORE);
		r.sys  = allow_sys & (a == ACT_SYS);
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// expiry detection
	assign act    = cfg.act[stage_r];
	assign live   = cfg.wd_en & tick & cfg.stage_en[stage_r];
	assign hit    = ({1'b0, cnt_r} + 33'h0_0001) >= {1'b0, cfg.tmo[stage_r]};
	assign expire = live & hit;
	assign is_rst = |decode_rst(act, ALLOW_SYS);

	// counter and stage; feed wins over counting so software can always restart
	always_ff @(posedge clk) begin
		if (srst || !cfg.wd_en || feed) begin
			cnt_r   <= '0;
			stage_r <= 2'h0;
		end else if (tick) begin
			if (!cfg.stage_en[stage_r]) begin
				cnt_r   <= '0;
				stage_r <= stage_r + 2'h1;
			end else if (hit) begin
				cnt_r   <= '0;
				stage_r <= is_rst ? 2'h0 : stage_r + 2'h1;
			end else begin
				cnt_r <= cnt_r + 32'h0000_0001;
			end
		end
	end

	// interrupt level; a new expiry wins over a feed in the same cycle
	always_ff @(posedge clk) begin
		if (srst) begin
			irq_r <= 1'b0;
		end else if (expire && act == ACT_INT) begin
			irq_r <= 1'b1;
		end else if (feed || !cfg.wd_en) begin
			irq_r <= 1'b0;
		end
	end

	// reset request pulses, scope decoded here from the stage action code
	always_ff @(posedge clk) begin
		if (srst) begin
			rst_r <= '0;
		end else begin
			rst_r <= expire ? decode_rst(act, ALLOW_SYS) : '0;
		end
	end

	assign stat.count = cnt_r;
	assign stat.stage = stage_r;
	assign stat.irq   = irq_r;
	assign rst_req    = rst_r;

	////////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	property p_cnt_step;
		live && !hit && !feed |=> cnt_r == $past(cnt_r) + 32'h0000_0001;
	endproperty
	a_cnt_step: assert property (p_cnt_step) else $error("counter did not step");

	property p_advance;
		expire && !is_rst && !feed |=> stage_r == $past(stage_r) + 2'h1 && cnt_r == '0;
	endproperty
	a_advance: assert property (p_advance) else $error("no advance on expiry");

	property p_skip;
		tick && cfg.wd_en && !cfg.stage_en[stage_r] && !feed |=> stage_r == $past(stage_r) + 2'h1;
	endproperty
	a_skip: assert property (p_skip) else $error("disabled stage not skipped");

	property p_irq;
		expire && act == ACT_INT |=> irq_r;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt not raised");

	property p_cpu;
		expire && act == ACT_CPU |=> rst_r.cpu && !rst_r.core && stage_r == 2'h0;
	endproperty
	a_cpu: assert property (p_cpu) else $error("cpu reset not requested");

	property p_core;
		expire && act == ACT_CORE |=> rst_r.core && !rst_r.cpu;
	endproperty
	a_core: assert property (p_core) else $error("core reset not requested");

	property p_sys;
		expire && act == ACT_SYS |=> rst_r.sys == ALLOW_SYS;
	endproperty
	a_sys: assert property (p_sys) else $error("system reset scope wrong");

	property p_feed;
		feed |=> cnt_r == '0 && stage_r == 2'h0;
	endproperty
	a_feed: assert property (p_feed) else $error("feed did not restart");

	c_wrap: cover property (expire && !is_rst && stage_r == 2'h3);
	c_irq:  cover property (expire && act == ACT_INT);
endmodule

// [core/sdw_watchdogs.sv]
// Purpose: three staged digital watchdogs behind a classic wishbone slave
// Assumes: all inputs synchronous to clk; rtc clock sources arrive as sampled levels
// Notes:   watchdogs 0 and 1 are main-system, watchdog 2 sits in the rtc domain
`timescale 1ns/1ps
module sdw_watchdogs #(
	parameter logic [31:0] BOOT_TMO_MAIN = 32'h0100_0000,
	parameter logic [31:0] BOOT_TMO_RTC  = 32'h0001_0000
) (
	input  wire logic        clk,
	input  wire logic        srst,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        flash_boot,
	input  wire logic        xtal32k_clk,
	input  wire logic        slow_rc_clk,
	input  wire logic        fast_rc_clk,
	output logic      [2:0]  wdt_irq,
	output logic             cpu_rst_req,
	output logic             core_rst_req,
	output logic             sys_rst_req
);
	import sdw_pkg::*;

	sdw_cfg_t             cfg_r [NUM_WDT];
	sdw_stat_t            stat  [NUM_WDT];
	sdw_rst_t             rstq  [NUM_WDT];
	logic [NUM_WDT-1:0]   lock_r;
	logic [NUM_WDT-1:0]   feed;
	logic [NUM_WDT-1:0]   tick;
	logic [1:0]           clksel_r;
	logic                 boot_arm_r;
	logic                 boot_mode_r;
	logic                 ack_r;
	logic [31:0]          dat_r;
	logic [31:0]          rd_data;
	logic                 wr_stb;
	logic [1:0]           wd_idx;
	logic [5:0]           ofs;
	logic [2:0]           src_prev_r;
	logic [FAST_DIV_W-1:0] div_r;
	logic                 rtc_tick;
	logic [2:0]           src_rise;
	logic                 cpu_r;
	logic                 core_r;
	logic                 sys_r;
	logic [2:0]           cpu_v;
	logic [2:0]           core_v;
	logic [2:0]           sys_v;
	logic [2:0]           irq_v;

	// byte-lane merge for partial writes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
	                                      input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		return r;
	endfunction

	// config word layout: enable, stage enables, stage actions
	function automatic logic [31:0] cfg_pack(input sdw_cfg_t c);
		logic [31:0] r;
		r = '0;
		r[CFG_EN_BIT] = c.wd_en;
		r[CFG_SEN_LSB +: NUM_STAGE] = c.stage_en;
		r[CFG_ACT_LSB +: NUM_STAGE*3] = c.act;
		return r;
	endfunction

	// automatic configuration armed while booting from flash
	function automatic sdw_cfg_t boot_cfg(input logic is_rtc);
		sdw_cfg_t c;
		c = '0;
		c.wd_en    = 1'b1;
		c.stage_en = 4'h1;
		c.act[0]   = is_rtc ? ACT_SYS : ACT_CORE;
		c.tmo[0]   = is_rtc ? BOOT_TMO_RTC : BOOT_TMO_MAIN;
		return c;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// wishbone decode
	assign wr_stb = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_r;
	assign wd_idx = wb_adr_i[7:6];
	assign ofs    = wb_adr_i[5:0];
	always_comb begin
		for (int w = 0; w < NUM_WDT; w++) begin
			feed[w] = wr_stb && wd_idx == w[1:0] && ofs == OFS_FEED;
		end
	end

	// the strap is caught in the cycle after reset release, never during reset
	always_ff @(posedge clk) begin
		if (srst) begin
			boot_arm_r  <= 1'b1;
			boot_mode_r <= 1'b0;
		end else if (boot_arm_r) begin
			boot_arm_r  <= 1'b0;
			boot_mode_r <= flash_boot;
		end
	end

	// configuration registers; the auto boot setup overrides any write that cycle
	always_ff @(posedge clk) begin
		if (srst) begin
			for (int w = 0; w < NUM_WDT; w++) begin
				cfg_r[w] <= '0;
			end
		end else if (boot_arm_r && flash_boot) begin
			cfg_r[0]       <= boot_cfg(1'b0);
			cfg_r[RTC_IDX] <= boot_cfg(1'b1);
		end else begin
			for (int w = 0; w < NUM_WDT; w++) begin
				if (wr_stb && wd_idx == w[1:0] && !lock_r[w]) begin
					if (ofs == OFS_CONFIG) begin
						cfg_r[w].wd_en    <= wb_dat_i[CFG_EN_BIT];
						cfg_r[w].stage_en <= wb_dat_i[CFG_SEN_LSB +: NUM_STAGE];
						cfg_r[w].act      <= wb_dat_i[CFG_ACT_LSB +: NUM_STAGE*3];
					end
					for (int s = 0; s < NUM_STAGE; s++) begin
						if (ofs == OFS_STAGE0 + 6'(s * 4)) begin
							cfg_r[w].tmo[s] <= merge(cfg_r[w].tmo[s], wb_dat_i, wb_sel_i);
						end
					end
				end
			end
		end
	end

	// write protection: the key unlocks, any other value locks again
	always_ff @(posedge clk) begin
		if (srst) begin
			lock_r <= {NUM_WDT{LOCK_RST}};
		end else begin
			for (int w = 0; w < NUM_WDT; w++) begin
				if (wr_stb && wd_idx == w[1:0] && ofs == OFS_WPROT) begin
					lock_r[w] <= (wb_dat_i != WPROT_KEY);
				end
			end
		end
	end

	// slow clock select belongs to the rtc watchdog and shares its lock
	always_ff @(posedge clk) begin
		if (srst) begin
			clksel_r <= CLKSEL_RST;
		end else if (wr_stb && wb_adr_i == OFS_CLKSEL && !lock_r[RTC_IDX]) begin
			clksel_r <= wb_dat_i[1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// rtc slow clock: sources are sampled levels, so rtc count resolution is one edge
	assign src_rise = {fast_rc_clk, slow_rc_clk, xtal32k_clk} & ~src_prev_r;
	always_ff @(posedge clk) begin
		if (srst) begin
			// follow the pins in reset so a source already high fakes no edge
			src_prev_r <= {fast_rc_clk, slow_rc_clk, xtal32k_clk};
			div_r      <= '0;
		end else begin
			src_prev_r <= {fast_rc_clk, slow_rc_clk, xtal32k_clk};
			if (src_rise[2]) begin
				div_r <= div_r + 8'h01;
			end
		end
	end

	always_comb begin
		case (clksel_r)
			CLK_XTAL32K:  rtc_tick = src_rise[0];
			CLK_SLOW_RC:  rtc_tick = src_rise[1];
			CLK_FAST_DIV: rtc_tick = src_rise[2] && (&div_r);
			default:      rtc_tick = 1'b0;
		endcase
	end
	assign tick = {rtc_tick, 1'b1, 1'b1};               // main watchdogs count clk

	////////////////////////////////////////////////////////////////////////////////
	// watchdog instances; only the rtc one may request a system reset
	for (genvar g = 0; g < NUM_WDT; g++) begin : g_wdt
		sdw_wdt_core #(
			.ALLOW_SYS (g == RTC_IDX)
		) u_core (
			.clk     (clk),
			.srst    (srst),
			.tick    (tick[g]),
			.feed    (feed[g]),
			.cfg     (cfg_r[g]),
			.stat    (stat[g]),
			.rst_req (rstq[g])
		);
	end

	always_comb begin
		for (int w = 0; w < NUM_WDT; w++) begin
			cpu_v[w]  = rstq[w].cpu;
			core_v[w] = rstq[w].core;
			sys_v[w]  = rstq[w].sys;
			irq_v[w]  = stat[w].irq;
		end
	end

	// reset outputs registered again so every top output leaves a flop
	always_ff @(posedge clk) begin
		if (srst) begin
			cpu_r  <= 1'b0;
			core_r <= 1'b0;
			sys_r  <= 1'b0;
		end else begin
			cpu_r  <= |cpu_v;
			core_r <= |core_v;
			sys_r  <= |sys_v;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read mux; unmapped addresses read zero and are still acknowledged
	always_comb begin
		rd_data = '0;
		if (wd_idx == GLOBAL_IDX) begin
			if (wb_adr_i == OFS_CLKSEL) begin
				rd_data = {30'h0000_0000, clksel_r};
			end else if (wb_adr_i == OFS_STRAP) begin
				rd_data = {31'h0000_0000, boot_mode_r};
			end
		end else begin
			case (ofs)
				OFS_CONFIG: rd_data = cfg_pack(cfg_r[wd_idx]);
				OFS_WPROT:  rd_data = {31'h0000_0000, lock_r[wd_idx]};
				OFS_STATUS: rd_data = {29'h0000_0000, stat[wd_idx].irq, stat[wd_idx].stage};
				OFS_COUNT:  rd_data = stat[wd_idx].count;
				default: begin
					if (ofs >= OFS_STAGE0 && ofs <= OFS_STAGE3 && ofs[1:0] == 2'h0) begin
						rd_data = cfg_r[wd_idx].tmo[ofs[3:2] - 2'h1];
					end
				end
			endcase
		end
	end

	// single-cycle answer: ack one edge after the request, dropped the next cycle
	always_ff @(posedge clk) begin
		if (srst) begin
			ack_r <= 1'b0;
			dat_r <= '0;
		end else begin
			ack_r <= wb_cyc_i & wb_stb_i & ~ack_r;
			if (wb_cyc_i && wb_stb_i && !wb_we_i && !ack_r) begin
				dat_r <= rd_data;
			end
		end
	end

	assign wb_ack_o     = ack_r;
	assign wb_dat_o     = dat_r;
	assign wdt_irq      = irq_v;
	assign cpu_rst_req  = cpu_r;
	assign core_rst_req = core_r;
	assign sys_rst_req  = sys_r;

	////////////////////////////////////////////////////////////////////////////////
	// checks
	property p_wprot;
		@(posedge clk) disable iff (srst)
		wr_stb && wd_idx == 2'h0 && lock_r[0] && !boot_arm_r |=> cfg_r[0] == $past(cfg_r[0]);
	endproperty
	a_wprot: assert property (p_wprot) else $error("locked config changed");

	property p_boot;
		@(posedge clk) disable iff (srst)
		boot_arm_r && flash_boot |=> cfg_r[0].wd_en && cfg_r[RTC_IDX].wd_en
		                            && cfg_r[RTC_IDX].act[0] == ACT_SYS;
	endproperty
	a_boot: assert property (p_boot) else $error("boot watchdogs not armed");

	property p_sys_out;
		@(posedge clk) disable iff (srst)
		rstq[RTC_IDX].sys |=> sys_rst_req;
	endproperty
	a_sys_out: assert property (p_sys_out) else $error("system reset lost");

	property p_main_nosys;
		@(posedge clk) disable iff (srst)
		!rstq[0].sys && !rstq[1].sys;
	endproperty
	a_main_nosys: assert property (p_main_nosys) else $error("main asked system reset");

	property p_rtc_tick;
		@(posedge clk) disable iff (srst)
		rtc_tick |-> src_rise[clksel_r];
	endproperty
	a_rtc_tick: assert property (p_rtc_tick) else $error("rtc tick from wrong source");

	property p_ack;
		@(posedge clk) disable iff (srst)
		wb_cyc_i && wb_stb_i && !ack_r |=> ack_r ##1 !ack_r;
	endproperty
	a_ack: assert property (p_ack) else $error("wishbone ack timing wrong");

	c_boot: cover property (@(posedge clk) boot_arm_r && flash_boot);
	c_core: cover property (@(posedge clk) core_rst_req);
	c_unlock: cover property (@(posedge clk) !lock_r[0] ##1 wr_stb && ofs == OFS_CONFIG);
endmodule

// [sim/tb_sdw_watchdogs.sv]
// Purpose: self-checking bench for the three staged digital watchdogs
// Assumes: boot strap high from time zero, so watchdogs 0 and 2 come up armed
// Notes:   reset request pulses are counted by a monitor and compared as deltas
`timescale 1ns/1ps
module tb_sdw_watchdogs;
	import sdw_pkg::*;

	logic        clk;
	logic        srst;
	logic        wb_cyc_i;
	logic        wb_stb_i;
	logic        wb_we_i;
	logic [7:0]  wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic        flash_boot;
	logic        xtal32k_clk;
	logic        slow_rc_clk;
	logic        fast_rc_clk;
	logic [2:0]  wdt_irq;
	logic        cpu_rst_req;
	logic        core_rst_req;
	logic        sys_rst_req;
	int          fail_count;
	int          checks;
	int          n_cpu = 0;
	int          n_core = 0;
	int          n_sys = 0;
	int          b_cpu;
	int          b_core;
	logic [31:0] rv;
	logic [3:0]  sel_v = 4'hF;

	// short boot timeouts keep the run brief
	sdw_watchdogs #(.BOOT_TMO_MAIN(32'h0000_0010), .BOOT_TMO_RTC(32'h0000_0004)) dut (
		.clk(clk), .srst(srst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .flash_boot(flash_boot),
		.xtal32k_clk(xtal32k_clk), .slow_rc_clk(slow_rc_clk), .fast_rc_clk(fast_rc_clk),
		.wdt_irq(wdt_irq), .cpu_rst_req(cpu_rst_req), .core_rst_req(core_rst_req),
		.sys_rst_req(sys_rst_req));

	////////////////////////////////////////////////////////////////////////////////
	// 40 MHz clock
	initial clk = 1'b0;
	always #12.5 clk = ~clk;

	// pulses last one cycle, so count them rather than poll them
	always @(posedge clk) begin
		if (cpu_rst_req === 1'b1) n_cpu <= n_cpu + 1;
		if (core_rst_req === 1'b1) n_core <= n_core + 1;
		if (sys_rst_req === 1'b1) n_sys <= n_sys + 1;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic final_report();
		if (fail_count == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	// classic single cycle; request held until ack is sampled high
	task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] wdat,
			output logic [31:0] rdat);
		int n;
		n = 0;
		@(posedge clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_sel_i <= sel_v;
		wb_adr_i <= adr;
		wb_dat_i <= wdat;
		do begin
			@(posedge clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		if (n >= 50) begin
			fail_count++;
			$display("ERROR wb_ack expected 1 seen %b", wb_ack_o);
		end
		rdat = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i  <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wr(input logic [1:0] wd, input logic [5:0] ofs, input logic [31:0] d);
		logic [31:0] dummy;
		bus(1'b1, {wd, ofs}, d, dummy);
	endtask

	task automatic rd(input logic [1:0] wd, input logic [5:0] ofs, output logic [31:0] d);
		bus(1'b0, {wd, ofs}, 32'h0000_0000, d);
	endtask

	// bounded wait: 0 cpu pulse, 1 core pulse, 2 sys pulse, 3 irq of watchdog 1
	task automatic wait_ev(input int sel, input int base, input int lim, output bit hit);
		int n;
		n = 0;
		hit = 1'b0;
		while (!hit && n < lim) begin
			@(posedge clk);
			n++;
			case (sel)
				0: hit = (n_cpu > base);
				1: hit = (n_core > base);
				2: hit = (n_sys > base);
				default: hit = (wdt_irq[1] === 1'b1);
			endcase
		end
	endtask

	// m picks the sources to pulse: bit0 xtal32k, bit1 slow rc, bit2 fast rc
	task automatic rtc_edges(input logic [2:0] m, input int n);
		repeat (n) begin
			@(posedge clk);
			{fast_rc_clk, slow_rc_clk, xtal32k_clk} <= m;
			repeat (2) @(posedge clk);
			{fast_rc_clk, slow_rc_clk, xtal32k_clk} <= 3'h0;
			repeat (2) @(posedge clk);
		end
	endtask

	function automatic logic [31:0] cfg(input logic [3:0] sen, input logic [2:0] a0,
			input logic [2:0] a1, input logic [2:0] a2, input logic [2:0] a3);
		return {12'h000, a3, a2, a1, a0, sen, 3'h0, 1'b1};
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// hang guard sized well above the roughly 1700 cycles the sequence needs
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		final_report();
	end

	initial begin
		bit hit;
		{wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'hF;
		wb_dat_i = 32'h0000_0000;
		{xtal32k_clk, slow_rc_clk, fast_rc_clk} = 3'h0;
		flash_boot = 1'b1;
		{fail_count, checks} = '0;
		srst = 1'b1;
		repeat (8) @(posedge clk);
		srst <= 1'b0;
		// boot strap captured, main watchdog 0 must reboot the core
		bus(1'b0, OFS_STRAP, 32'h0000_0000, rv);
		chk("strap", rv, 32'h0000_0001);
		wait_ev(1, 0, 100, hit);
		chk("boot core reset", 32'(hit), 32'h0000_0001);
		chk("boot cpu reset", 32'(n_cpu), 32'h0000_0000);
		// rtc watchdog counts slow clock edges and asks for a system reset
		rtc_edges(3'h1, 6);
		chk("rtc sys reset", 32'(n_sys > 0), 32'h0000_0001);
		// boot protection ends: unlock and disable watchdogs 0 and 2
		wr(2'd0, OFS_WPROT, WPROT_KEY);
		wr(2'd0, OFS_CONFIG, 32'h0000_0000);
		wr(2'd2, OFS_WPROT, WPROT_KEY);
		wr(2'd2, OFS_CONFIG, 32'h0000_0000);
		rd(2'd2, OFS_WPROT, rv);
		chk("wprot unlocked", rv & 32'h0000_0001, 32'h0000_0000);
		bus(1'b1, OFS_CLKSEL, {30'h0, CLK_SLOW_RC}, rv);
		bus(1'b0, OFS_CLKSEL, 32'h0000_0000, rv);
		chk("clksel", rv, {30'h0, CLK_SLOW_RC});
		bus(1'b0, 8'hD0, 32'h0000_0000, rv);
		chk("unmapped", rv, 32'h0000_0000);
		// locked watchdog 1 ignores configuration writes
		wr(2'd1, OFS_CONFIG, 32'h0000_00F1);
		rd(2'd1, OFS_CONFIG, rv);
		chk("locked cfg", rv, 32'h0000_0000);
		wr(2'd1, OFS_WPROT, WPROT_KEY);
		for (int s = 0; s < 4; s++) begin
			wr(2'd1, OFS_STAGE0 + 6'(4 * s), 32'h0000_0014);
			rd(2'd1, OFS_STAGE0 + 6'(4 * s), rv);
			chk("stage tmo", rv, 32'h0000_0014);
		end
		// byte enables: only lane 0 of stage1 may change
		sel_v = 4'h1;
		wr(2'd1, OFS_STAGE0 + 6'h04, 32'hFFFF_FF33);
		sel_v = 4'hF;
		rd(2'd1, OFS_STAGE0 + 6'h04, rv);
		chk("stage sel", rv, 32'h0000_0033);
		// stage0 irq, stage1 skipped, stage2 cpu reset
		b_cpu = n_cpu;
		b_core = n_core;
		wr(2'd1, OFS_CONFIG, cfg(4'b1101, ACT_INT, ACT_INT, ACT_CPU, ACT_INT));
		rd(2'd1, OFS_STATUS, rv);
		chk("status start", rv, 32'h0000_0000);
		rd(2'd1, OFS_COUNT, rv);
		chk("count runs", 32'(rv > 0 && rv < 32'h0000_0014), 32'h0000_0001);
		wait_ev(3, 0, 40, hit);
		chk("irq raised", 32'(hit), 32'h0000_0001);
		rd(2'd1, OFS_STATUS, rv);
		chk("status stage2", rv, 32'h0000_0006);
		wait_ev(0, b_cpu, 40, hit);
		chk("cpu reset", 32'(hit), 32'h0000_0001);
		chk("no core reset", 32'(n_core - b_core), 32'h0000_0000);
		wr(2'd1, OFS_FEED, 32'h0000_0000);
		rd(2'd1, OFS_STATUS, rv);
		chk("fed status", rv, 32'h0000_0000);
		// steady feeding keeps every stage from expiring
		b_cpu = n_cpu;
		repeat (6) begin
			repeat (8) @(posedge clk);
			wr(2'd1, OFS_FEED, 32'h0000_0000);
		end
		chk("fed irq", {29'h0, wdt_irq}, 32'h0000_0000);
		chk("fed no reset", 32'(n_cpu - b_cpu), 32'h0000_0000);
		// stage3 is the last enabled stage, so expiry wraps to stage0
		wr(2'd1, OFS_STAGE0, 32'h0000_0028);
		wr(2'd1, OFS_STAGE3, 32'h0000_0004);
		wr(2'd1, OFS_CONFIG, cfg(4'b1001, ACT_INT, ACT_OFF, ACT_OFF, ACT_INT));
		wait_ev(3, 0, 80, hit);
		chk("wrap irq", 32'(hit), 32'h0000_0001);
		repeat (20) @(posedge clk);
		rd(2'd1, OFS_STATUS, rv);
		chk("wrap stage", rv, 32'h0000_0004);
		wr(2'd1, OFS_CONFIG, 32'h0000_0000);
		// rtc watchdog on the slow rc: xtal edges must not count
		wr(2'd2, OFS_STAGE0, 32'h0000_0002);
		wr(2'd2, OFS_CONFIG, cfg(4'b0001, ACT_INT, ACT_OFF, ACT_OFF, ACT_OFF));
		rtc_edges(3'h1, 4);
		chk("rtc xtal ignored", {31'h0, wdt_irq[2]}, 32'h0000_0000);
		rtc_edges(3'h2, 2);
		chk("rtc slow irq", {31'h0, wdt_irq[2]}, 32'h0000_0001);
		// fast rc divided by 256: one tick on the 256th edge
		wr(2'd2, OFS_STAGE0, 32'h0000_0001);
		bus(1'b1, OFS_CLKSEL, {30'h0, CLK_FAST_DIV}, rv);
		wr(2'd2, OFS_FEED, 32'h0000_0000);
		rtc_edges(3'h4, 255);
		chk("rtc div early", {31'h0, wdt_irq[2]}, 32'h0000_0000);
		rtc_edges(3'h4, 1);
		chk("rtc div irq", {31'h0, wdt_irq[2]}, 32'h0000_0001);
		// relocked rtc watchdog refuses a clock select write
		wr(2'd2, OFS_WPROT, 32'h0000_0000);
		bus(1'b1, OFS_CLKSEL, {30'h0, CLK_XTAL32K}, rv);
		bus(1'b0, OFS_CLKSEL, 32'h0000_0000, rv);
		chk("clksel locked", rv, {30'h0, CLK_FAST_DIV});
		final_report();
	end
endmodule
